// file: verilog/playback_pkg.sv
// Package: shared constants for the playback host transfer block.
// Assumes a 200 MHz clock; all timing counts derive from CLK_PERIOD_NS.
package playback_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int FRAME_PERIOD_MS = 30;
    localparam int FRAME_CYCLES = FRAME_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [15:0] CMD_IDLE = 16'h0000;
    localparam logic [15:0] CMD_RATE_5K3 = 16'h5232;
    localparam logic [15:0] CMD_POLL_SYNC = 16'h5202;
    localparam logic [15:0] CMD_STOP = 16'h5220;
    localparam logic [15:0] CMD_BUF_MON = 16'h5212;
    localparam logic [11:0] CMD_DEPTH_HI = 12'h528;
    localparam logic [15:0] CMD_FIRST_TS = 16'h2c03;
    localparam logic [15:0] CMD_FIRST_LIN = 16'h2c63;
    localparam logic [15:0] CMD_SECOND = 16'h2000;
    localparam logic [3:0] CMD_THIRD_TOP = 4'h2;
    localparam logic [15:0] RESP_ZERO_WORDS = 16'h2000;
    localparam logic [15:0] RESP_OK = 16'h0000;
    localparam logic [1:0] PATH_TX_PORT = 2'h3;
    localparam int PATH_LSB = 0;
    localparam int FORMAT_LSB = 4;
    localparam logic [2:0] FORMAT_LINEAR16 = 3'h6;
    localparam logic [7:0] LINEAR16_WORDS = 8'hf0;
    localparam int QUEUE_WORDS = 240;
    localparam int BURST_WORDS = 16;
    localparam int DEPTH_UNIT = 16;
    localparam int HWCTL_MASTER_IE = 10;
    localparam int HWCTL_DMA_DIR = 8;
    localparam int HWCTL_DMA_BURST = 7;
    localparam int HWCTL_TX_FREE_IE = 1;
    localparam int HWCTL_TX_DMA_EN = 5;
endpackage

// file: verilog/word_buffer.sv
// Two-entry valid/ready buffer on the transmit data path.
// Assumes both sides share one clock.
`timescale 1ns/1ps
module word_buffer
    import playback_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    if (WIDTH < 1) begin : g_width_check
        $error("WIDTH must be positive");
    end
    logic [WIDTH-1:0] mem_q [2];
    logic [1:0] count_q;
    logic wr_ptr_q, rd_ptr_q;
    logic push, pop;
    assign in_ready = count_q != 2'h2;
    assign out_valid = count_q != 2'h0;
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            count_q <= 2'h0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
        end else begin
            if (push) wr_ptr_q <= ~wr_ptr_q;
            if (pop) rd_ptr_q <= ~rd_ptr_q;
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge clk) begin
        if (push) mem_q[wr_ptr_q] <= in_data;
    end
endmodule

// file: verilog/pin_sync.sv
// Three-stage synchroniser; output changes when stages two and three agree.
// Assumes an asynchronous pin level at the input.
`timescale 1ns/1ps
module pin_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rst_val,
    input wire logic pin,
    output logic level
);
    logic s1_q, s2_q, s3_q, level_q;
    // Stages start at the pin's idle level, so no false edge after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= rst_val;
            s2_q <= rst_val;
            s3_q <= rst_val;
            level_q <= rst_val;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) level_q <= s3_q;
        end
    end
    assign level = level_q;
endmodule

// file: verilog/playback_host_transfer_control.sv
// Playback command/response handshake and transmit data path of the
// host port. Assumes the host bus decode outside presents one-cycle
// write and read strobes per register on CLOCK.
`timescale 1ns/1ps
module playback_host_transfer_control
    import playback_pkg::*;
#(
    parameter int FRAME_CYC = FRAME_CYCLES,
    parameter int QUEUE_DEPTH = QUEUE_WORDS,
    parameter int BURST_LEN = BURST_WORDS
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic CMD_WRITE,
    input wire logic [15:0] CMD_DATA,
    input wire logic RESP_READ,
    output logic [15:0] RESP_DATA,
    output logic CMD_SLOT_FREE,
    output logic RESP_PENDING,
    input wire logic HWCTL_WRITE,
    input wire logic [15:0] HWCTL_DATA,
    output logic [15:0] HWCTL_VALUE,
    input wire logic TX_WRITE,
    input wire logic [15:0] TX_DATA,
    output logic TX_FREE,
    output logic IRQ,
    output logic tx_dma_request,
    input wire logic tx_dma_ack_n,
    output logic PLAYING,
    output logic [7:0] QUEUE_LEVEL,
    output logic FRAME_TICK
);
    // Queue level and burst counter are 8 bits wide
    if (FRAME_CYC < 1 || QUEUE_DEPTH < BURST_LEN || QUEUE_DEPTH > 255) begin : g_param_check
        $error("Unsupported playback parameters");
    end
    if (BURST_LEN < 1 || BURST_LEN > 255) begin : g_burst_check
        $error("BURST_LEN out of range");
    end

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_WAIT_SECOND = 5'b00010,
        ST_WAIT_THIRD = 5'b00100,
        ST_PLAY = 5'b01000,
        ST_SPARE = 5'b10000
    } play_state_e;

    play_state_e state_q;
    logic [15:0] cmd_q, resp_q, hwctl_q;
    logic cmd_full_q, pending_q, resp_load;
    logic [15:0] resp_d;
    logic [2:0] playback_format_code_q;
    logic [1:0] transfer_path_code_q;
    logic [7:0] frame_words_q, depth_q, queue_q, burst_cnt_q;
    logic [31:0] frame_cnt_q;
    logic tx_free_q, flush, take, ack, deq_frame;
    logic buf_valid, buf_ready, in_ready;
    logic [15:0] buf_data;
    logic [7:0] frame_len;

    pin_sync ack_sync (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .rst_val(1'b1),
        .pin(tx_dma_ack_n),
        .level(ack)
    );

    // Command latched on write; slot reopens once the command is taken
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            cmd_full_q <= 1'b0;
            cmd_q <= 16'h0000;
        end else if (CMD_WRITE) begin
            cmd_full_q <= 1'b1;
            cmd_q <= CMD_DATA;
        end else if (take) begin
            cmd_full_q <= 1'b0;
        end
    end
    // Taken only while no unread answer stands, so no response is lost
    assign take = cmd_full_q && !pending_q;
    assign CMD_SLOT_FREE = !cmd_full_q;

    always_comb begin
        resp_d = RESP_OK;
        case (state_q)
            ST_WAIT_SECOND: resp_d = cmd_q;
            ST_WAIT_THIRD: begin
                if (transfer_path_code_q == PATH_TX_PORT &&
                    cmd_q[7:0] == LINEAR16_WORDS)
                    resp_d = RESP_ZERO_WORDS;
                else
                    resp_d = cmd_q;
            end
            default: begin
                if (cmd_q == CMD_FIRST_TS || cmd_q == CMD_FIRST_LIN)
                    resp_d = cmd_q;
                else if (cmd_q == CMD_BUF_MON)
                    resp_d = {8'h00, queue_q};
                else if (cmd_q[15:4] == CMD_DEPTH_HI)
                    resp_d = cmd_q;
            end
        endcase
        // Stop and idle always win, whatever the state
        if (cmd_q == CMD_IDLE || cmd_q == CMD_STOP) resp_d = RESP_OK;
    end
    assign resp_load = take;

    // Set wins over the host read clearing the flag
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            pending_q <= 1'b0;
            resp_q <= 16'h0000;
        end else if (resp_load) begin
            pending_q <= 1'b1;
            resp_q <= resp_d;
        end else if (RESP_READ) begin
            pending_q <= 1'b0;
        end
    end
    assign RESP_DATA = resp_q;
    assign RESP_PENDING = pending_q;

    assign flush = take && (cmd_q == CMD_IDLE || cmd_q == CMD_STOP);

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            state_q <= ST_IDLE;
            playback_format_code_q <= 3'h0;
            transfer_path_code_q <= 2'h0;
            frame_words_q <= 8'h00;
        end else if (flush) begin
            state_q <= ST_IDLE;
        end else if (take) begin
            case (state_q)
                ST_IDLE, ST_PLAY: begin
                    if (cmd_q == CMD_FIRST_TS || cmd_q == CMD_FIRST_LIN) begin
                        playback_format_code_q <= cmd_q[FORMAT_LSB+2:FORMAT_LSB];
                        transfer_path_code_q <= cmd_q[PATH_LSB+1:PATH_LSB];
                        state_q <= ST_WAIT_SECOND;
                    end
                end
                ST_WAIT_SECOND: begin
                    if (cmd_q == CMD_SECOND) state_q <= ST_WAIT_THIRD;
                end
                ST_WAIT_THIRD: begin
                    if (cmd_q[15:12] == CMD_THIRD_TOP) begin
                        frame_words_q <= cmd_q[7:0];
                        state_q <= ST_PLAY;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    assign PLAYING = state_q == ST_PLAY;

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            depth_q <= 8'(QUEUE_DEPTH);
        end else if (take && cmd_q[15:4] == CMD_DEPTH_HI) begin
            // Depth in units of 16 words; zero keeps the full queue
            if (cmd_q[3:0] == 4'h0)
                depth_q <= 8'(QUEUE_DEPTH);
            else
                depth_q <= 8'(cmd_q[3:0] * DEPTH_UNIT);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) hwctl_q <= 16'h0000;
        else if (HWCTL_WRITE) hwctl_q <= HWCTL_DATA;
    end
    assign HWCTL_VALUE = hwctl_q;

    word_buffer #(.WIDTH(16)) tx_buf (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .flush(flush),
        .in_valid(TX_WRITE && PLAYING),
        .in_ready(in_ready),
        .in_data(TX_DATA),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );
    // Up to two words past the queue limit stall in the buffer; later ones are dropped
    assign buf_ready = queue_q < depth_q;

    assign frame_len = (playback_format_code_q == FORMAT_LINEAR16) ?
        LINEAR16_WORDS : frame_words_q;

    always_ff @(posedge CLOCK) begin
        if (!RESET_N || flush || !PLAYING) begin
            frame_cnt_q <= 32'h0;
        end else if (frame_cnt_q == 32'(FRAME_CYC - 1)) begin
            frame_cnt_q <= 32'h0;
        end else begin
            frame_cnt_q <= frame_cnt_q + 32'h1;
        end
    end
    assign deq_frame = PLAYING && frame_cnt_q == 32'(FRAME_CYC - 1);
    assign FRAME_TICK = deq_frame;

    // Only the queue level is modelled; sample data is discarded here
    always_ff @(posedge CLOCK) begin
        if (!RESET_N || flush) begin
            queue_q <= 8'h00;
        end else begin
            queue_q <= queue_q
                + {7'h00, buf_valid && buf_ready}
                - ((deq_frame && queue_q >= frame_len) ? frame_len :
                   (deq_frame ? queue_q : 8'h00));
        end
    end
    assign QUEUE_LEVEL = queue_q;

    // Free while playing with queue room; a DMA burst drops it
    always_ff @(posedge CLOCK) begin
        if (!RESET_N || flush) begin
            tx_free_q <= 1'b0;
            burst_cnt_q <= 8'h00;
        end else if (!PLAYING) begin
            tx_free_q <= 1'b0;
        end else if (!ack && TX_WRITE && in_ready) begin
            if (burst_cnt_q == 8'(BURST_LEN - 1)) begin
                burst_cnt_q <= 8'h00;
                tx_free_q <= 1'b0;
            end else begin
                burst_cnt_q <= burst_cnt_q + 8'h01;
            end
        end else if (!buf_valid) begin
            tx_free_q <= queue_q < depth_q;
        end
    end
    assign TX_FREE = tx_free_q;
    assign IRQ = tx_free_q && hwctl_q[HWCTL_MASTER_IE] &&
        hwctl_q[HWCTL_TX_FREE_IE];
    assign tx_dma_request = tx_free_q && hwctl_q[HWCTL_TX_DMA_EN] &&
        hwctl_q[HWCTL_DMA_BURST];
    // Data words reaching the queue are not observable here; buf_data
    // only feeds unused_data and drives no output of this block.
    logic unused_data;
    assign unused_data = ^buf_data;
endmodule

// file: verification/playback_monitor.sv
// Checker for the playback host transfer block, bound to its top ports.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module playback_monitor
    import playback_pkg::*;
#(
    parameter int QUEUE_DEPTH = 240
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic CMD_WRITE,
    input wire logic [15:0] CMD_DATA,
    input wire logic RESP_READ,
    input wire logic [15:0] RESP_DATA,
    input wire logic CMD_SLOT_FREE,
    input wire logic RESP_PENDING,
    input wire logic [15:0] HWCTL_VALUE,
    input wire logic TX_FREE,
    input wire logic IRQ,
    input wire logic tx_dma_request,
    input wire logic PLAYING,
    input wire logic [7:0] QUEUE_LEVEL,
    input wire logic FRAME_TICK
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    logic take_ok;
    // Only a write into an empty response slot has a fixed answer time
    assign take_ok = CMD_WRITE && !RESP_PENDING;
    property p_slot; CMD_WRITE |=> !CMD_SLOT_FREE; endproperty
    a_slot: assert property (p_slot) else $error("slot flag stayed set");
    property p_ans; take_ok |-> ##2 RESP_PENDING; endproperty
    a_ans: assert property (p_ans) else $error("no response posted");
    property p_read; RESP_READ && CMD_SLOT_FREE |=> !RESP_PENDING; endproperty
    a_read: assert property (p_read) else $error("pending not cleared");
    property p_rise; $rose(RESP_PENDING) |-> CMD_SLOT_FREE; endproperty
    a_rise: assert property (p_rise) else $error("pending before take");
    property p_irq; IRQ == (TX_FREE && HWCTL_VALUE[HWCTL_MASTER_IE]
        && HWCTL_VALUE[HWCTL_TX_FREE_IE]); endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch");
    property p_dreq; tx_dma_request == (TX_FREE && HWCTL_VALUE[HWCTL_TX_DMA_EN]
        && HWCTL_VALUE[HWCTL_DMA_BURST]); endproperty
    a_dreq: assert property (p_dreq) else $error("dma request mismatch");
    property p_stop; take_ok && (CMD_DATA == CMD_STOP || CMD_DATA == CMD_IDLE)
        |-> ##2 (RESP_DATA == RESP_OK && !PLAYING && !TX_FREE); endproperty
    a_stop: assert property (p_stop) else $error("stop not honoured");
    property p_first; take_ok && (CMD_DATA == CMD_FIRST_TS
        || CMD_DATA == CMD_FIRST_LIN) |-> ##2 RESP_DATA == $past(CMD_DATA, 2);
    endproperty
    a_first: assert property (p_first) else $error("first word not echoed");
    property p_mode; take_ok && (CMD_DATA == CMD_RATE_5K3
        || CMD_DATA == CMD_POLL_SYNC) |-> ##2 RESP_DATA == RESP_OK; endproperty
    a_mode: assert property (p_mode) else $error("mode reply wrong");
    property p_level; QUEUE_LEVEL <= QUEUE_DEPTH; endproperty
    a_level: assert property (p_level) else $error("queue overfilled");
    c_read: cover property (RESP_READ);
    c_irq: cover property (IRQ);
    c_dreq: cover property (tx_dma_request);
    c_tick: cover property (FRAME_TICK && PLAYING);
endmodule
bind playback_host_transfer_control playback_monitor #(
    .QUEUE_DEPTH(QUEUE_DEPTH)) mon_u (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .CMD_WRITE(CMD_WRITE), .CMD_DATA(CMD_DATA), .RESP_READ(RESP_READ),
    .RESP_DATA(RESP_DATA), .CMD_SLOT_FREE(CMD_SLOT_FREE),
    .RESP_PENDING(RESP_PENDING), .HWCTL_VALUE(HWCTL_VALUE),
    .TX_FREE(TX_FREE), .IRQ(IRQ), .tx_dma_request(tx_dma_request),
    .PLAYING(PLAYING), .QUEUE_LEVEL(QUEUE_LEVEL), .FRAME_TICK(FRAME_TICK));

// file: verification/dma_partner.sv
// External DMA controller model: bursts 16 words per request.
// Assumes the device syncs the acknowledge over a few cycles.
`timescale 1ns/1ps
module dma_partner (
    input wire logic clk,
    input wire logic req,
    output logic ack_n,
    output logic wr,
    output logic [15:0] data
);
    initial begin
        int i;
        bit slow;
        ack_n = 1'b1;
        wr = 1'b0;
        data = 16'h0000;
        slow = 1'b0;
        forever begin
            @(posedge clk);
            #1;
            if (req === 1'b1) begin
                ack_n = 1'b0;
                // Give the acknowledge time to cross the synchroniser
                repeat (6) @(posedge clk);
                #1;
                for (i = 0; i < 16; i++) begin
                    wr = 1'b1;
                    data = 16'h1000 + 16'(i);
                    @(posedge clk);
                    #1;
                    if (slow) begin
                        wr = 1'b0;
                        data = ~data;
                        @(posedge clk);
                        #1;
                    end
                end
                wr = 1'b0;
                data = ~data;
                ack_n = 1'b1;
                slow = !slow;
                repeat (8) @(posedge clk);
            end
        end
    end
endmodule

// file: verification/testbench.sv
// Self-checking bench: host task calls plus a DMA partner model.
// Assumes a shortened frame period so playback runs in few cycles.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
    import playback_pkg::*;
    logic CLOCK = 0, RESET_N = 0, CMD_WRITE = 0, RESP_READ = 0;
    logic HWCTL_WRITE = 0, host_wr = 0;
    logic [15:0] CMD_DATA = 0, HWCTL_DATA = 0, host_d = 0;
    logic [15:0] RESP_DATA, HWCTL_VALUE, dma_d;
    logic CMD_SLOT_FREE, RESP_PENDING, TX_FREE, IRQ, tx_dma_request;
    logic tx_dma_ack_n, PLAYING, FRAME_TICK, dma_wr;
    logic [7:0] QUEUE_LEVEL;
    int bad_count = 0, num_checks = 0, cyc = 0, f, n;
    playback_host_transfer_control #(.FRAME_CYC(4000)) dut_u (
        .CLOCK(CLOCK), .RESET_N(RESET_N), .CMD_WRITE(CMD_WRITE),
        .CMD_DATA(CMD_DATA), .RESP_READ(RESP_READ), .RESP_DATA(RESP_DATA),
        .CMD_SLOT_FREE(CMD_SLOT_FREE), .RESP_PENDING(RESP_PENDING),
        .HWCTL_WRITE(HWCTL_WRITE), .HWCTL_DATA(HWCTL_DATA),
        .HWCTL_VALUE(HWCTL_VALUE), .TX_WRITE(host_wr | dma_wr),
        .TX_DATA(dma_wr ? dma_d : host_d), .TX_FREE(TX_FREE), .IRQ(IRQ),
        .tx_dma_request(tx_dma_request), .tx_dma_ack_n(tx_dma_ack_n),
        .PLAYING(PLAYING), .QUEUE_LEVEL(QUEUE_LEVEL), .FRAME_TICK(FRAME_TICK));
    dma_partner dma_u (.clk(CLOCK), .req(tx_dma_request),
        .ack_n(tx_dma_ack_n), .wr(dma_wr), .data(dma_d));
    initial forever #2.5 CLOCK = ~CLOCK;
    task automatic tick(input int k);
        repeat (k) @(posedge CLOCK);
        #1;
    endtask
    task automatic cmd(input logic [15:0] c, input logic [15:0] e);
        int w;
        w = 0;
        while (CMD_SLOT_FREE !== 1'b1 && w < 100) begin
            tick(1);
            w++;
        end
        CMD_WRITE = 1'b1;
        CMD_DATA = c;
        tick(1);
        CMD_WRITE = 1'b0;
        w = 0;
        while (RESP_PENDING !== 1'b1 && w < 100) begin
            tick(1);
            w++;
        end
        `CHK(RESP_DATA, e);
        RESP_READ = 1'b1;
        tick(1);
        RESP_READ = 1'b0;
        tick(1);
        `CHK(RESP_PENDING, 1'b0);
    endtask
    task automatic hw(input logic [15:0] d);
        HWCTL_WRITE = 1'b1;
        HWCTL_DATA = d;
        tick(1);
        HWCTL_WRITE = 1'b0;
        tick(1);
        `CHK(HWCTL_VALUE, d);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Ceiling well above the one frame period the run needs
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        tick(6);
        RESET_N = 1'b1;
        tick(1);
        `CHK({CMD_SLOT_FREE, RESP_PENDING, TX_FREE}, 3'b100);
        cmd(CMD_RATE_5K3, RESP_OK);
        cmd(CMD_POLL_SYNC, RESP_OK);
        cmd(CMD_FIRST_TS, 16'h2c03);
        cmd(CMD_SECOND, 16'h2000);
        cmd(16'h200a, 16'h200a);
        `CHK(PLAYING, 1'b1);
        hw(16'h0402);
        for (f = 0; f < 30; f++) begin
            n = 0;
            while (IRQ !== 1'b1 && n < 40) begin
                tick(1);
                n++;
            end
            if (IRQ !== 1'b1) break;
            for (n = 0; n < 10; n++) begin
                host_wr = 1'b1;
                host_d = 16'(f * 10 + n);
                tick(1);
            end
            host_wr = 1'b0;
            tick(4);
        end
        `CHK(f, 24);
        `CHK(QUEUE_LEVEL, 8'd240);
        cmd(CMD_BUF_MON, 16'h00f0);
        n = 0;
        while (FRAME_TICK !== 1'b1 && n < 4100) begin
            tick(1);
            n++;
        end
        tick(3);
        `CHK(QUEUE_LEVEL >= 8'd230 && QUEUE_LEVEL <= 8'd232, 1'b1);
        hw(16'h0000);
        cmd(CMD_STOP, RESP_OK);
        `CHK({PLAYING, TX_FREE, IRQ, QUEUE_LEVEL}, 11'h000);
        cmd(16'h5282, 16'h5282);
        cmd(CMD_POLL_SYNC, RESP_OK);
        cmd(CMD_FIRST_LIN, 16'h2c63);
        cmd(CMD_SECOND, 16'h2000);
        cmd(16'h20f0, RESP_ZERO_WORDS);
        hw(16'h01a0);
        tick(200);
        `CHK(QUEUE_LEVEL, 8'd32);
        `CHK(tx_dma_request, 1'b0);
        hw(16'h00a0);
        hw(16'h0000);
        cmd(CMD_IDLE, RESP_OK);
        `CHK({PLAYING, QUEUE_LEVEL}, 9'h000);
        report_and_stop();
    end
endmodule
